// File: logic/rfa_pkg.sv
// Constants and types for the banked register file and address generation block.
package rfa_pkg;

	// Data and address widths of the core.
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;
	// Bank geometry: eight registers per bank, up to four banks.
	localparam int BANK_REGS = 8;
	localparam int NUM_BANKS = 4;
	localparam int RF_DEPTH = NUM_BANKS * BANK_REGS;

	// Reset values of the stack pointer halves, of the status register and of the program counter.
	localparam logic [7:0] STACK_PAGE_RST = 8'h01;
	localparam logic [7:0] SP_LOW_RST = 8'hFF;
	localparam logic [7:0] PSR_RST = 8'h08;
	localparam logic [15:0] PC_RST = 16'h0000;
	// Opcode forced into the opcode register by reset or an interrupt.
	localparam logic [7:0] INT_OPCODE = 8'h00;

	// Field positions inside the status register.
	localparam int PSR_MASK_BIT = 3;
	localparam int PSR_FLAG_LSB = 4;
	localparam int NUM_FLAGS = 4;
	// Control register bit that enables the extra banks.
	localparam int CTRL_EXT_BANK_BIT = 0;

	// Byte offsets on the software register port.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STACK_PAGE = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_PC = 8'h0C;
	localparam logic [7:0] REG_SP = 8'h10;
	localparam logic [7:0] REG_ADDR = 8'h14;

	// Bus cycle requested by the instruction decoder for the next cycle.
	typedef enum logic [2:0] {CMD_IDLE, CMD_FETCH, CMD_OPERAND, CMD_READ, CMD_WRITE, CMD_PUSH,
		CMD_POP} rfa_cmd_e;
	// Address source for plain data reads and writes.
	typedef enum logic [1:0] {ASRC_DIRECT, ASRC_INDEX, ASRC_INDEX_OFS} rfa_asrc_e;
	// Write data selector.
	typedef enum logic [1:0] {WD_REG, WD_PC_HI, WD_PC_LO} rfa_wdsel_e;

endpackage

// File: logic/rfa_core.sv
// Banked register file, address generation and bus signalling of the 8-bit core.
`timescale 1ns/1ps

module rfa_core
	import rfa_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	// Memory and IO bus side.
	output logic [ADDR_W-1:0] addr,
	output logic [ADDR_W-1:0] addr_nxt,
	input wire logic [DATA_W-1:0] read_data_bus,
	output logic [DATA_W-1:0] write_data_bus,
	output logic read_strobe,
	output logic write_strobe,
	input wire logic ready,
	output logic op_fetch,
	input wire logic [7:0] int_req,
	input wire logic [NUM_FLAGS-1:0] flag_set_lines,
	input wire logic [NUM_FLAGS-1:0] flag_clear_lines,
	output logic [7:0] processor_status_reg,
	// Instruction decoder side.
	input wire rfa_cmd_e cmd,
	input wire rfa_asrc_e addr_src,
	input wire rfa_wdsel_e wd_sel,
	input wire logic [ADDR_W-1:0] direct_addr,
	input wire logic [DATA_W-1:0] addr_offset,
	input wire logic idx_pair_sel,
	input wire logic [2:0] rf_a_sel,
	input wire logic [2:0] rf_b_sel,
	input wire logic rf_wr_en,
	input wire logic [DATA_W-1:0] rf_wr_data,
	output logic [DATA_W-1:0] rf_a_data,
	output logic [DATA_W-1:0] rf_b_data,
	output logic [DATA_W-1:0] accumulator_reg,
	input wire logic pc_load,
	input wire logic [ADDR_W-1:0] pc_load_val,
	input wire logic psr_wr_en,
	input wire logic [3:0] psr_wr_data,
	output logic [DATA_W-1:0] opcode,
	output logic [DATA_W-1:0] captured_data,
	output logic int_pending,
	output logic [2:0] int_source,
	output logic reset_entry,
	// Software register port.
	input wire logic [7:0] sw_addr,
	input wire logic [15:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [15:0] sw_rdata
);

	// Storage for all banks, addressed as {bank, register}.
	logic [DATA_W-1:0] regs_r [RF_DEPTH];
	// Program counter and stack pointer.
	logic [ADDR_W-1:0] program_counter;
	logic [ADDR_W-1:0] stack_pointer;
	// Registered address bus.
	logic [ADDR_W-1:0] addr_r;
	// Status register, control register and bus outputs.
	logic [7:0] psr_r;
	logic [7:0] ctrl_r;
	logic [DATA_W-1:0] wd_r;
	logic rd_stb_r;
	logic wr_stb_r;
	logic fetch_r;
	logic [DATA_W-1:0] opcode_r;
	logic [DATA_W-1:0] cap_r;
	logic reset_entry_r;
	logic [2:0] int_src_r;
	logic [15:0] sw_rdata_r;
	// Two-stage synchronisers for pin inputs.
	logic [7:0] int_s1_r;
	logic [7:0] int_s2_r;
	logic [NUM_FLAGS-1:0] fset_s1_r;
	logic [NUM_FLAGS-1:0] fset_s2_r;
	logic [NUM_FLAGS-1:0] fclr_s1_r;
	logic [NUM_FLAGS-1:0] fclr_s2_r;
	// Combinational helpers.
	logic [1:0] bank;
	logic [ADDR_W-1:0] index_addr;
	logic [ADDR_W-1:0] addr_calc;
	logic int_take;
	logic maskable_req;
	logic [2:0] int_low;
	logic [DATA_W-1:0] wd_mux;
	logic is_write;
	logic is_read;

	// Builds the flat storage index from a bank and a register number.
	function automatic logic [4:0] rf_index(input logic [1:0] b, input logic [2:0] r);
		rf_index = {b, r};
	endfunction

	// Bank select: the mask bit picks the interrupt bank; a user flag adds two more banks when the control bit enables them.
	// mask selects bank
	assign bank = {ctrl_r[CTRL_EXT_BANK_BIT] & psr_r[PSR_FLAG_LSB], psr_r[PSR_MASK_BIT]};

	// Port A reads the register that a write would also target; port B only reads.
	// read/write plus read-only port
	assign rf_a_data = regs_r[rf_index(bank, rf_a_sel)];
	assign rf_b_data = regs_r[rf_index(bank, rf_b_sel)];
	assign accumulator_reg = regs_r[rf_index(bank, 3'h0)];

	// Index pair: the higher-numbered register of the pair is the high byte.
	// pairs form addresses
	assign index_addr = {regs_r[rf_index(bank, {1'b1, idx_pair_sel, 1'b1})],
		regs_r[rf_index(bank, {1'b1, idx_pair_sel, 1'b0})]};

	// Single write port, on port A; a frozen cycle writes nothing.
	// one write per cycle
	always_ff @(posedge ref_clk) begin
		if (ready && rf_wr_en) begin
			regs_r[rf_index(bank, rf_a_sel)] <= rf_wr_data;
		end
	end

	// Next-cycle address for the requested bus cycle.
	always_comb begin
		addr_calc = addr_r;
		unique case (cmd)
			CMD_IDLE: begin
				addr_calc = addr_r;
			end
			CMD_FETCH, CMD_OPERAND: begin
				addr_calc = program_counter;
			end
			CMD_READ, CMD_WRITE: begin
				unique case (addr_src)
					ASRC_DIRECT: begin
						addr_calc = direct_addr;
					end
					ASRC_INDEX: begin
						addr_calc = index_addr;
					end
					ASRC_INDEX_OFS: begin
						addr_calc = index_addr + {8'h00, addr_offset};
					end
					default: begin
						addr_calc = direct_addr;
					end
				endcase
			end
			CMD_PUSH: begin
				addr_calc = stack_pointer - 16'h0001;
			end
			CMD_POP: begin
				addr_calc = stack_pointer;
			end
			default: begin
				addr_calc = addr_r;
			end
		endcase
	end

	// While frozen the next address is the held one, so outside predecode stays valid.
	// predecode source offered
	assign addr_nxt = ready ? addr_calc : addr_r;
	assign is_write = (cmd == CMD_WRITE) || (cmd == CMD_PUSH);
	assign is_read = (cmd == CMD_FETCH) || (cmd == CMD_OPERAND) || (cmd == CMD_READ) || (cmd == CMD_POP);

	// Address register: the bus address comes straight from flip-flops.
	// registered address
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			addr_r <= PC_RST;
		end else if (ready) begin
			addr_r <= addr_calc;
		end
	end

	// Program counter: a load wins over the increment of a fetch or operand read.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			program_counter <= PC_RST;
		end else if (ready) begin
			if (pc_load) begin
				program_counter <= pc_load_val;
			end else if ((cmd == CMD_FETCH) || (cmd == CMD_OPERAND)) begin
				program_counter <= program_counter + 16'h0001;
			end
		end
	end

	// Stack pointer: software may move the stack page; pushes and pops count it.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stack_pointer <= {STACK_PAGE_RST, SP_LOW_RST};
		end else if (sw_wr && (sw_addr == REG_STACK_PAGE)) begin
			stack_pointer <= {sw_wdata[7:0], stack_pointer[7:0]};
		end else if (sw_wr && (sw_addr == REG_SP)) begin
			stack_pointer <= sw_wdata;
		end else if (ready) begin
			if (cmd == CMD_PUSH) begin
				stack_pointer <= stack_pointer - 16'h0001;
			end else if (cmd == CMD_POP) begin
				stack_pointer <= stack_pointer + 16'h0001;
			end
		end
	end

	// Write data selector: register data or either half of the return address.
	always_comb begin
		wd_mux = rf_a_data;
		unique case (wd_sel)
			WD_REG: begin
				wd_mux = rf_a_data;
			end
			WD_PC_HI: begin
				wd_mux = program_counter[15:8];
			end
			WD_PC_LO: begin
				wd_mux = program_counter[7:0];
			end
			default: begin
				wd_mux = rf_a_data;
			end
		endcase
	end

	// Bus strobes and write data are all registered with the address.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wd_r <= 8'h00;
			rd_stb_r <= 1'b0;
			wr_stb_r <= 1'b0;
			fetch_r <= 1'b0;
		end else if (ready) begin
			wr_stb_r <= is_write;
			if (is_write) begin
				wd_r <= wd_mux;
			end
			rd_stb_r <= is_read;
			fetch_r <= (cmd == CMD_FETCH);
		end
	end

	// Pin synchronisers for interrupts and flag lines.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			int_s1_r <= 8'h00;
			int_s2_r <= 8'h00;
			fset_s1_r <= 4'h0;
			fset_s2_r <= 4'h0;
			fclr_s1_r <= 4'h0;
			fclr_s2_r <= 4'h0;
		end else begin
			int_s1_r <= int_req;
			int_s2_r <= int_s1_r;
			fset_s1_r <= flag_set_lines;
			fset_s2_r <= fset_s1_r;
			fclr_s1_r <= flag_clear_lines;
			fclr_s2_r <= fclr_s1_r;
		end
	end

	// Interrupt acceptance: line zero ignores the mask, the rest obey it.
	// line zero non-maskable
	assign maskable_req = (|int_s2_r[7:1]) && !psr_r[PSR_MASK_BIT];
	assign int_take = int_s2_r[0] || maskable_req;
	assign int_pending = int_take;

	// Lowest-numbered accepted line, reported with the forced opcode.
	always_comb begin
		int_low = 3'h0;
		for (int i = 7; i >= 1; i--) begin
			if (int_s2_r[i] && !psr_r[PSR_MASK_BIT]) begin
				int_low = 3'(i);
			end
		end
		if (int_s2_r[0]) begin
			int_low = 3'h0;
		end
	end

	// Opcode register: a fetch that meets an interrupt takes the interrupt opcode.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			opcode_r <= INT_OPCODE;
			reset_entry_r <= 1'b1;
			int_src_r <= 3'h0;
		end else if (ready && rd_stb_r && fetch_r) begin
			reset_entry_r <= 1'b0;
			int_src_r <= int_low;
			opcode_r <= int_take ? INT_OPCODE : read_data_bus;
		end
	end

	// Data captured from the read bus on a completed read cycle.
	// freeze until ready
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cap_r <= 8'h00;
		end else if (ready && rd_stb_r) begin
			cap_r <= read_data_bus;
		end
	end

	// Status register: low nibble from the decoder, flags also from the pins.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			psr_r[3:0] <= PSR_RST[3:0];
		end else if (ready && psr_wr_en) begin
			psr_r[3:0] <= psr_wr_data;
		end
	end

	// Each flag: set line wins, then clear line, then a software write.
	generate
		for (genvar f = 0; f < NUM_FLAGS; f++) begin : g_flag
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					psr_r[PSR_FLAG_LSB+f] <= PSR_RST[PSR_FLAG_LSB+f];
				end else if (fset_s2_r[f]) begin
					psr_r[PSR_FLAG_LSB+f] <= 1'b1;
				end else if (fclr_s2_r[f]) begin
					psr_r[PSR_FLAG_LSB+f] <= 1'b0;
				end else if (sw_wr && (sw_addr == REG_STATUS)) begin
					psr_r[PSR_FLAG_LSB+f] <= sw_wdata[PSR_FLAG_LSB+f];
				end
			end
		end
	endgenerate

	// Control register written by software.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_r <= 8'h00;
		end else if (sw_wr && (sw_addr == REG_CTRL)) begin
			ctrl_r <= sw_wdata[7:0];
		end
	end

	// Software read data, valid the cycle after the read strobe; unmapped reads zero.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sw_rdata_r <= 16'h0000;
		end else if (sw_rd) begin
			unique case (sw_addr)
				REG_CTRL: begin
					sw_rdata_r <= {8'h00, ctrl_r};
				end
				REG_STACK_PAGE: begin
					sw_rdata_r <= {8'h00, stack_pointer[15:8]};
				end
				REG_STATUS: begin
					sw_rdata_r <= {8'h00, psr_r};
				end
				REG_PC: begin
					sw_rdata_r <= program_counter;
				end
				REG_SP: begin
					sw_rdata_r <= stack_pointer;
				end
				REG_ADDR: begin
					sw_rdata_r <= addr_r;
				end
				default: begin
					sw_rdata_r <= 16'h0000;
				end
			endcase
		end else begin
			sw_rdata_r <= 16'h0000;
		end
	end

	// Output wiring from the registers.
	assign addr = addr_r;
	assign write_data_bus = wd_r;
	assign read_strobe = rd_stb_r;
	assign write_strobe = wr_stb_r;
	assign op_fetch = fetch_r;
	assign processor_status_reg = psr_r;
	assign opcode = opcode_r;
	assign captured_data = cap_r;
	assign int_source = int_src_r;
	assign reset_entry = reset_entry_r;
	assign sw_rdata = sw_rdata_r;

endmodule

// File: tb/rfa_core_asserts.sv
// Concurrent checks on the bus, status and interrupt ports of the core.
`timescale 1ns/1ps
module rfa_core_asserts
	import rfa_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [15:0] addr,
	input wire logic [15:0] addr_nxt,
	input wire logic [7:0] write_data_bus,
	input wire logic read_strobe,
	input wire logic write_strobe,
	input wire logic ready,
	input wire logic op_fetch,
	input wire logic [7:0] int_req,
	input wire logic [3:0] flag_set_lines,
	input wire logic [7:0] processor_status_reg,
	input wire rfa_cmd_e cmd,
	input wire rfa_wdsel_e wd_sel,
	input wire logic [7:0] rf_a_data,
	input wire logic pc_load,
	input wire logic int_pending
);
	// All checks use the core clock and pause in reset.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_addr_reg: assert property (1'b1 |=> addr == $past(addr_nxt))
		else $error("address not the registered next address");
	a_ready_freeze: assert property (!ready |=> $stable(addr) && $stable(write_data_bus) && $stable(read_strobe))
		else $error("bus outputs moved during a stall");
	a_fetch_read: assert property (ready && cmd == CMD_FETCH |=> op_fetch && read_strobe && !write_strobe)
		else $error("fetch cycle without read strobe");
	a_write_mux: assert property (ready && cmd == CMD_WRITE && wd_sel == WD_REG
		|=> write_strobe && write_data_bus == $past(rf_a_data))
		else $error("write data not the register value");
	a_pc_step: assert property (ready && cmd == CMD_FETCH && op_fetch && !pc_load && !int_pending
		|=> addr == $past(addr) + 16'h0001)
		else $error("fetch address did not step by one");
	a_nmi_pend: assert property (int_req[0] [*3] |-> int_pending)
		else $error("lowest interrupt line not pending");
	a_mask_hold: assert property ((!int_req[0]) [*3] ##0 processor_status_reg[3] |-> !int_pending)
		else $error("masked interrupt seen as pending");
	a_flag_set: assert property (flag_set_lines[0] [*3] |=> processor_status_reg[4])
		else $error("flag set line did not set the flag");
	a_wstrobe_src: assert property (write_strobe
		|-> $past(ready && (cmd == CMD_WRITE || cmd == CMD_PUSH)) || $past(!ready && write_strobe))
		else $error("write strobe without a write request");
endmodule

// File: tb/rfa_mem_model.sv
// Behavioural memory partner that answers the core's bus cycles with random stalls.
`timescale 1ns/1ps
module rfa_mem_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic [15:0] addr,
	input wire logic [15:0] addr_nxt,
	input wire logic read_strobe,
	input wire logic write_strobe,
	input wire logic [7:0] write_data_bus,
	output logic ready,
	output logic [7:0] read_data_bus
);
	// Byte storage; each byte starts as a pattern of its address.
	logic [7:0] mem [0:65535];
	// Last byte shown, so an idle bus carries its inverse.
	logic [7:0] last_r = 8'h00;
	// Page select decoded a cycle early.
	logic [7:0] page_r = 8'h00;
	initial begin
		ready = 1'b1;
		for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8] ^ 8'hA5;
	end
	always @(posedge ref_clk) page_r <= addr_nxt[15:8];
	// Data only while strobed; a released bus never repeats its value.
	assign read_data_bus = read_strobe ? mem[{page_r, addr[7:0]}] : ~last_r;
	// Stores on accepted writes and draws the stall pattern.
	always @(posedge ref_clk) begin
		if (read_strobe) last_r <= read_data_bus;
		if (write_strobe && ready) mem[addr] <= write_data_bus;
		ready <= rst || !slow || ($urandom_range(3) != 0);
	end
endmodule

// File: tb/test_risc8_regfile_address_gen.sv
// Self-checking bench for the banked register file and address generation core.
`timescale 1ns/1ps
module test_risc8_regfile_address_gen
	import rfa_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst, slow, ready, read_strobe, write_strobe, op_fetch, idx_pair_sel, rf_wr_en, pc_load;
	logic psr_wr_en, int_pending, reset_entry, sw_wr, sw_rd;
	logic [15:0] addr, addr_nxt, direct_addr, pc_load_val, sw_wdata, sw_rdata, pc_m, sp_m, v;
	logic [7:0] read_data_bus, write_data_bus, int_req, processor_status_reg, addr_offset, rf_wr_data;
	logic [7:0] rf_a_data, rf_b_data, accumulator_reg, opcode, captured_data, sw_addr;
	logic [3:0] flag_set_lines, flag_clear_lines, psr_wr_data;
	logic [2:0] rf_a_sel, rf_b_sel, int_source;
	rfa_cmd_e cmd;
	rfa_asrc_e addr_src;
	rfa_wdsel_e wd_sel;
	// Bench copies of memory and of the four register banks.
	logic [7:0] mem_m [0:65535];
	logic [7:0] rf_m [0:3][0:7];
	int err_count = 0;
	int compares = 0;
	int cycles = 0;
	rfa_core u_rfa_core (
		.ref_clk(ref_clk), .rst(rst), .addr(addr), .addr_nxt(addr_nxt), .read_data_bus(read_data_bus),
		.write_data_bus(write_data_bus), .read_strobe(read_strobe), .write_strobe(write_strobe),
		.ready(ready), .op_fetch(op_fetch), .int_req(int_req), .flag_set_lines(flag_set_lines),
		.flag_clear_lines(flag_clear_lines), .processor_status_reg(processor_status_reg), .cmd(cmd),
		.addr_src(addr_src), .wd_sel(wd_sel), .direct_addr(direct_addr), .addr_offset(addr_offset),
		.idx_pair_sel(idx_pair_sel), .rf_a_sel(rf_a_sel), .rf_b_sel(rf_b_sel), .rf_wr_en(rf_wr_en),
		.rf_wr_data(rf_wr_data), .rf_a_data(rf_a_data), .rf_b_data(rf_b_data), .accumulator_reg(accumulator_reg),
		.pc_load(pc_load), .pc_load_val(pc_load_val), .psr_wr_en(psr_wr_en), .psr_wr_data(psr_wr_data),
		.opcode(opcode), .captured_data(captured_data), .int_pending(int_pending), .int_source(int_source),
		.reset_entry(reset_entry), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
		.sw_rdata(sw_rdata)
	);
	rfa_mem_model u_rfa_mem_model (
		.ref_clk(ref_clk), .rst(rst), .slow(slow), .addr(addr), .addr_nxt(addr_nxt), .read_strobe(read_strobe),
		.write_strobe(write_strobe), .write_data_bus(write_data_bus), .ready(ready), .read_data_bus(read_data_bus)
	);
	// Clock toggles every half period.
	always #2.5 ref_clk = ~ref_clk;
	// A hang counts as a mismatch and ends the run.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			complete_run();
		end
	end
	// Compares a value with its expectation.
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Waits for an edge at which ready is high.
	task wait_rdy();
		do @(posedge ref_clk); while (ready !== 1'b1);
	endtask
	// One software access; a read checks the data of the next cycle.
	task sw_op(input logic wr, input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= wr;
		sw_rd <= !wr;
		@(posedge ref_clk);
		sw_wr <= 1'b0;
		sw_rd <= 1'b0;
		#1;
		if (!wr) chk(sw_rdata, d);
	endtask
	// Writes the low status nibble.
	task set_psr(input logic [3:0] d);
		@(posedge ref_clk);
		psr_wr_en <= 1'b1;
		psr_wr_data <= d;
		@(posedge ref_clk);
		psr_wr_en <= 1'b0;
		#1;
	endtask
	// Pulses the flag lines long enough to pass the synchroniser.
	task flag(input logic [3:0] s, input logic [3:0] c);
		@(posedge ref_clk);
		flag_set_lines <= s;
		flag_clear_lines <= c;
		repeat (3) @(posedge ref_clk);
		flag_set_lines <= 4'h0;
		flag_clear_lines <= 4'h0;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask
	// Fills the active bank with random bytes.
	task rf_fill(input int b);
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			rf_m[b][i] = 8'($urandom);
			rf_a_sel <= i[2:0];
			rf_wr_data <= rf_m[b][i];
			rf_wr_en <= 1'b1;
		end
		@(posedge ref_clk);
		rf_wr_en <= 1'b0;
	endtask
	// Reads the active bank through both ports at once.
	task rf_check(input int b);
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			rf_a_sel <= i[2:0];
			rf_b_sel <= ~i[2:0];
			#1;
			chk(rf_a_data, rf_m[b][i]);
			chk(rf_b_data, rf_m[b][7 - i]);
			chk(accumulator_reg, rf_m[b][0]);
		end
	endtask
	// Back-to-back opcode fetches, n of them.
	task fetch_run(input int n);
		@(posedge ref_clk);
		cmd <= CMD_FETCH;
		for (int i = 0; i <= n; i++) begin
			wait_rdy();
			if (i == n - 1) cmd <= CMD_IDLE;
			#1;
			if (i > 0) chk(opcode, mem_m[pc_m - 16'h0001]);
			if (i < n) begin
				chk(addr, pc_m);
				chk({op_fetch, read_strobe}, 2'b11);
				pc_m++;
			end
		end
	endtask
	// One data or stack cycle; stack addresses come from the pointer copy.
	task bus_op(input rfa_cmd_e c, input logic [15:0] a, input logic [7:0] wd);
		logic wr;
		wr = (c == CMD_WRITE) || (c == CMD_PUSH);
		if (c == CMD_PUSH) sp_m--;
		if (c == CMD_PUSH || c == CMD_POP) a = sp_m;
		if (c == CMD_POP) sp_m++;
		@(posedge ref_clk);
		cmd <= c;
		wait_rdy();
		cmd <= CMD_IDLE;
		#1;
		chk(addr, a);
		chk({write_strobe, read_strobe}, {wr, !wr});
		if (wr) chk(write_data_bus, wd);
		wait_rdy();
		#1;
		if (wr) mem_m[a] = wd;
		else chk(captured_data, mem_m[a]);
	endtask
	// Prints the counts and the verdict, then stops.
	task complete_run();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Main sequence.
	initial begin
		void'($urandom(32'h84C8));
		for (int i = 0; i < 65536; i++) mem_m[i] = i[7:0] ^ i[15:8] ^ 8'hA5;
		rst = 1'b1;
		{slow, int_req, flag_set_lines, flag_clear_lines, direct_addr, addr_offset, idx_pair_sel} = '0;
		{rf_a_sel, rf_b_sel, rf_wr_en, rf_wr_data, pc_load, pc_load_val, psr_wr_en, psr_wr_data} = '0;
		{sw_addr, sw_wdata, sw_wr, sw_rd} = '0;
		cmd = CMD_IDLE;
		addr_src = ASRC_DIRECT;
		wd_sel = WD_REG;
		pc_m = PC_RST;
		sp_m = {STACK_PAGE_RST, SP_LOW_RST};
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		#1;
		chk(addr, PC_RST);
		chk({write_strobe, read_strobe, op_fetch, reset_entry}, 4'h1);
		chk(processor_status_reg, PSR_RST);
		chk(opcode, INT_OPCODE);
		sw_op(1'b0, REG_SP, sp_m);
		sw_op(1'b0, 8'hFC, 16'h0000);
		$display("reset test done");
		rf_fill(1);
		set_psr(4'h0);
		rf_fill(0);
		rf_check(0);
		set_psr(4'h8);
		rf_check(1);
		sw_op(1'b1, REG_CTRL, 16'h0001);
		flag(4'h1, 4'h0);
		chk(processor_status_reg, 8'h18);
		rf_fill(3);
		set_psr(4'h0);
		rf_fill(2);
		set_psr(4'h8);
		rf_check(3);
		flag(4'h0, 4'h1);
		chk(processor_status_reg, 8'h08);
		rf_check(1);
		$display("bank test done");
		slow <= 1'b1;
		fetch_run(6);
		v = 16'($urandom);
		@(posedge ref_clk);
		pc_load <= 1'b1;
		pc_load_val <= v;
		wait_rdy();
		pc_load <= 1'b0;
		pc_m = v;
		fetch_run(3);
		bus_op(CMD_OPERAND, pc_m, 8'h00);
		pc_m++;
		sw_op(1'b0, REG_PC, pc_m);
		$display("fetch test done");
		addr_src <= ASRC_INDEX;
		bus_op(CMD_READ, {rf_m[1][5], rf_m[1][4]}, 8'h00);
		addr_src <= ASRC_INDEX_OFS;
		idx_pair_sel <= 1'b1;
		addr_offset <= 8'hFF;
		bus_op(CMD_READ, {rf_m[1][7], rf_m[1][6]} + 16'h00FF, 8'h00);
		v = 16'($urandom);
		addr_src <= ASRC_DIRECT;
		direct_addr <= v;
		rf_a_sel <= 3'h2;
		bus_op(CMD_WRITE, v, rf_m[1][2]);
		bus_op(CMD_READ, v, 8'h00);
		sp_m = 16'h0180;
		sw_op(1'b1, REG_SP, sp_m);
		wd_sel <= WD_PC_HI;
		bus_op(CMD_PUSH, 16'h0000, pc_m[15:8]);
		wd_sel <= WD_PC_LO;
		bus_op(CMD_PUSH, 16'h0000, pc_m[7:0]);
		bus_op(CMD_POP, 16'h0000, 8'h00);
		bus_op(CMD_POP, 16'h0000, 8'h00);
		sw_op(1'b0, REG_SP, sp_m);
		$display("bus test done");
		slow <= 1'b0;
		int_req <= 8'h02;
		repeat (4) @(posedge ref_clk);
		#1;
		chk(int_pending, 1'b0);
		set_psr(4'h0);
		chk(int_pending, 1'b1);
		int_req <= 8'h01;
		set_psr(4'h8);
		repeat (3) @(posedge ref_clk);
		#1;
		chk(int_pending, 1'b1);
		sw_op(1'b0, REG_STATUS, 16'h0008);
		// An unmasked request meets an opcode fetch: the interrupt opcode and line two are reported.
		int_req <= 8'h0C;
		set_psr(4'h0);
		@(posedge ref_clk);
		cmd <= CMD_FETCH;
		wait_rdy();
		cmd <= CMD_IDLE;
		wait_rdy();
		#1;
		chk(opcode, INT_OPCODE);
		chk(int_source, 3'h2);
		chk(reset_entry, 1'b0);
		$display("interrupt test done");
		complete_run();
	end
endmodule

bind rfa_core rfa_core_asserts u_rfa_core_asserts (
	.ref_clk(ref_clk), .rst(rst), .addr(addr), .addr_nxt(addr_nxt), .write_data_bus(write_data_bus),
	.read_strobe(read_strobe), .write_strobe(write_strobe), .ready(ready), .op_fetch(op_fetch),
	.int_req(int_req), .flag_set_lines(flag_set_lines), .processor_status_reg(processor_status_reg),
	.cmd(cmd), .wd_sel(wd_sel), .rf_a_data(rf_a_data), .pc_load(pc_load), .int_pending(int_pending)
);
